// *** pic_defs.vh ***
`ifndef PIC_DEFS_VH
`define PIC_DEFS_VH
`define PIC_NSRC 8
`define PIC_A_FLAG 5'h00
`define PIC_A_ISP 5'h01
`define PIC_A_USP 5'h02
`define PIC_A_ESEL 5'h03
`define PIC_A_STAT 5'h04
`define PIC_A_CTRL0 5'h08
`define PIC_C_PEND 3
`define PIC_C_POL 4
`define PIC_F_D 2
`define PIC_F_I 6
`define PIC_F_U 7
`define PIC_RST_FLAG 16'h0000
`define PIC_RST_SP 16'h0000
`define PIC_INFO_ADDR 20'h00000
`define PIC_VEC_BASE 20'hffd00
`define PIC_FIX_BASE 20'hfffe0
`define PIC_TRAP_LO 6'd32
`define PIC_IPL_WDT 3'h7
`define PIC_K_MASK 3'h0
`define PIC_K_TRAP 3'h1
`define PIC_K_DBC 3'h2
`define PIC_K_WDT 3'h3
`define PIC_K_STEP 3'h4
`define PIC_K_AM 3'h5
`endif

// *** pic_priority_interrupt_control.v ***
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pic_defs.vh"
module pic_priority_interrupt_control (
	input wire mclk,
	input wire rst_n,
	input wire [4:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [15:0] reg_rdata,
	input wire [3:0] ext_pin,
	input wire [3:0] periph_req,
	input wire instr_done,
	input wire string_op_active,
	input wire trap_req,
	input wire [5:0] trap_num,
	input wire dbc_req,
	input wire wdt_req,
	input wire step_req,
	input wire addr_match_req,
	input wire reti_req,
	input wire [19:0] cur_pc,
	output wire seq_busy,
	output wire suspend,
	output wire info_rd,
	output wire [19:0] info_addr,
	output wire vec_rd,
	output wire [19:0] vec_addr,
	input wire [19:0] vec_rdata,
	output wire stk_we,
	output wire stk_re,
	output wire stk_byte,
	output wire [19:0] stk_addr,
	output wire [15:0] stk_wdata,
	input wire [15:0] stk_rdata,
	output reg pc_load,
	output reg [19:0] pc_out,
	output wire [15:0] flags_out
);
	localparam S_IDLE = 4'd0;
	localparam S_INFO = 4'd1;
	localparam S_FLG = 4'd2;
	localparam S_PSHF = 4'd3;
	localparam S_PSHP = 4'd4;
	localparam S_VEC = 4'd5;
	localparam S_POPP = 4'd6;
	localparam S_POPF = 4'd7;
	localparam S_POPD = 4'd8;

	// interrupt number of each maskable source
	function [5:0] src_num;
		input [2:0] s;
		begin
			case (s)
				3'd0: src_num = 6'd29;
				3'd1: src_num = 6'd30;
				3'd2: src_num = 6'd31;
				3'd3: src_num = 6'd4;
				3'd4: src_num = 6'd21;
				3'd5: src_num = 6'd22;
				3'd6: src_num = 6'd23;
				default: src_num = 6'd24;
			endcase
		end
	endfunction

	reg [3:0] state_q;
	reg [15:0] flag_q;
	reg [15:0] isp_q;
	reg [15:0] usp_q;
	reg [3:0] esel_q;
	reg [7:0] pend_q;
	reg [2:0] lvl_q [0:7];
	reg [7:0] pol_q;
	reg [3:0] pin_q;
	reg primed_q;
	reg [3:0] spec_q;
	reg [2:0] kind_q;
	reg [5:0] num_q;
	reg [2:0] src_q;
	reg [2:0] alvl_q;
	reg [15:0] tmp_flg_q;
	reg [19:0] tmp_pc_q;
	reg use_usp_q;
	reg odd_q;
	reg bph_q;
	reg [15:0] pop_pc_q;
	reg [2:0] best_lvl;
	reg [2:0] best_src;
	reg best_ok;
	reg [2:0] sel_kind;
	reg sel_ok;
	reg [15:0] rd_d;
	integer i;
	integer j;

	wire [2:0] current_priority_threshold = flag_q[14:12];
	wire [3:0] ext_edge;
	wire [7:0] src_req;
	wire [7:0] hw_clr;
	wire [15:0] sp_cur;
	wire [15:0] item0;
	wire [15:0] push_data;
	wire push_st;
	wire [15:0] push_off;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_ext
			// both edges when select set, else polarity 1 rising / 0 falling
			assign ext_edge[g] = primed_q && (esel_q[g] ? (ext_pin[g] ^ pin_q[g]) :
				(pol_q[g] ? (ext_pin[g] & ~pin_q[g]) : (~ext_pin[g] & pin_q[g])));
		end
	endgenerate

	// no edge before the first sample after reset is taken
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_q <= 4'h0;
			primed_q <= 1'b0;
		end
		else
		begin
			pin_q <= ext_pin;
			primed_q <= 1'b1;
		end
	end

	assign src_req = {periph_req, ext_edge};
	assign hw_clr = (state_q == S_INFO && kind_q == `PIC_K_MASK) ? (8'h01 << src_q) : 8'h00;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_q <= 8'h00;
			pol_q <= 8'h00;
			for (i = 0; i < `PIC_NSRC; i = i + 1)
				lvl_q[i] <= 3'h0;
		end
		else
		begin
			for (i = 0; i < `PIC_NSRC; i = i + 1)
			begin
				// set beats any clear in the same cycle
				if (src_req[i])
					pend_q[i] <= 1'b1;
				else if (hw_clr[i])
					pend_q[i] <= 1'b0;
				else if (reg_we && reg_addr == (`PIC_A_CTRL0 + i[4:0]) && !reg_wdata[`PIC_C_PEND])
					pend_q[i] <= 1'b0;
				if (reg_we && reg_addr == (`PIC_A_CTRL0 + i[4:0]))
				begin
					lvl_q[i] <= reg_wdata[2:0];
					pol_q[i] <= reg_wdata[`PIC_C_POL];
				end
			end
		end
	end

	// special sources held until their own acceptance
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			spec_q <= 4'h0;
		else
		begin
			spec_q[0] <= dbc_req | (spec_q[0] & ~(state_q == S_INFO && kind_q == `PIC_K_DBC));
			spec_q[1] <= wdt_req | (spec_q[1] & ~(state_q == S_INFO && kind_q == `PIC_K_WDT));
			spec_q[2] <= step_req | (spec_q[2] & ~(state_q == S_INFO && kind_q == `PIC_K_STEP));
			spec_q[3] <= addr_match_req | (spec_q[3] & ~(state_q == S_INFO && kind_q == `PIC_K_AM));
		end
	end

	// resolver; strict compare keeps the lowest index on a level tie
	always @*
	begin
		best_lvl = current_priority_threshold;
		best_src = 3'h0;
		best_ok = 1'b0;
		// own loop index so the clocked loop and this one never share a variable
		for (j = 0; j < `PIC_NSRC; j = j + 1)
		begin
			if (pend_q[j] && lvl_q[j] > best_lvl)
			begin
				best_lvl = lvl_q[j];
				best_src = j[2:0];
				best_ok = 1'b1;
			end
		end
	end

	always @*
	begin
		sel_ok = 1'b1;
		sel_kind = `PIC_K_MASK;
		if (spec_q[0])
			sel_kind = `PIC_K_DBC;
		else if (spec_q[1])
			sel_kind = `PIC_K_WDT;
		else if (trap_req && instr_done)
			sel_kind = `PIC_K_TRAP;
		else if (best_ok && flag_q[`PIC_F_I])
			sel_kind = `PIC_K_MASK;
		else if (spec_q[2] && flag_q[`PIC_F_D])
			sel_kind = `PIC_K_STEP;
		else if (spec_q[3])
			sel_kind = `PIC_K_AM;
		else
			sel_ok = 1'b0;
	end

	wire eval = instr_done | string_op_active;
	wire take = state_q == S_IDLE && !reti_req && eval && sel_ok;
	assign suspend = take && !instr_done;
	wire trap_hi = trap_num >= `PIC_TRAP_LO;

	assign sp_cur = use_usp_q ? usp_q : isp_q;
	assign item0 = {tmp_pc_q[19:16], 1'b0, tmp_flg_q[14:12], tmp_flg_q[7:0]};
	assign push_data = (state_q == S_PSHF) ? item0 : tmp_pc_q[15:0];
	assign push_st = state_q == S_PSHF || state_q == S_PSHP;
	// odd pointer: high byte first at sp-1, then low byte at sp-2
	assign push_off = (odd_q && !bph_q) ? 16'h0001 : 16'h0002;
	assign stk_we = push_st;
	assign stk_byte = push_st && odd_q;
	assign stk_wdata = !odd_q ? push_data : (bph_q ? {8'h00, push_data[7:0]} : {8'h00, push_data[15:8]});
	assign stk_re = state_q == S_POPP || state_q == S_POPF;
	assign stk_addr = {4'h0, push_st ? (sp_cur - push_off) :
		(state_q == S_POPF ? (sp_cur + 16'h0002) : sp_cur)};
	assign info_rd = state_q == S_INFO && kind_q == `PIC_K_MASK;
	assign info_addr = `PIC_INFO_ADDR;
	assign vec_rd = state_q == S_VEC;
	assign vec_addr = (kind_q == `PIC_K_MASK || kind_q == `PIC_K_TRAP) ?
		(`PIC_VEC_BASE + {12'h000, num_q, 2'b00}) : (`PIC_FIX_BASE + {15'h0000, kind_q, 2'b00});
	assign seq_busy = state_q != S_IDLE;
	assign flags_out = flag_q;

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_IDLE;
			flag_q <= `PIC_RST_FLAG;
			isp_q <= `PIC_RST_SP;
			usp_q <= `PIC_RST_SP;
			esel_q <= 4'h0;
			kind_q <= `PIC_K_MASK;
			num_q <= 6'h00;
			src_q <= 3'h0;
			alvl_q <= 3'h0;
			tmp_flg_q <= 16'h0000;
			tmp_pc_q <= 20'h00000;
			use_usp_q <= 1'b0;
			odd_q <= 1'b0;
			bph_q <= 1'b0;
			pop_pc_q <= 16'h0000;
			pc_load <= 1'b0;
			pc_out <= 20'h00000;
		end
		else
		begin
			pc_load <= 1'b0;
			if (reg_we && state_q == S_IDLE)
			begin
				case (reg_addr)
					`PIC_A_FLAG: flag_q <= reg_wdata;
					`PIC_A_ISP: isp_q <= reg_wdata;
					`PIC_A_USP: usp_q <= reg_wdata;
					`PIC_A_ESEL: esel_q <= reg_wdata[3:0];
					default: ;
				endcase
			end
			case (state_q)
				S_IDLE:
				begin
					bph_q <= 1'b0;
					if (reti_req)
					begin
						use_usp_q <= flag_q[`PIC_F_U];
						state_q <= S_POPP;
					end
					else if (take)
					begin
						kind_q <= sel_kind;
						src_q <= best_src;
						alvl_q <= best_lvl;
						num_q <= (sel_kind == `PIC_K_TRAP) ? trap_num : src_num(best_src);
						tmp_flg_q <= flag_q;
						tmp_pc_q <= cur_pc;
						use_usp_q <= sel_kind == `PIC_K_TRAP && trap_hi && flag_q[`PIC_F_U];
						odd_q <= (sel_kind == `PIC_K_TRAP && trap_hi && flag_q[`PIC_F_U]) ?
							usp_q[0] : isp_q[0];
						state_q <= S_INFO;
					end
				end
				S_INFO: state_q <= S_FLG;
				S_FLG:
				begin
					flag_q[`PIC_F_I] <= 1'b0;
					flag_q[`PIC_F_D] <= 1'b0;
					if (!(kind_q == `PIC_K_TRAP && num_q >= `PIC_TRAP_LO))
						flag_q[`PIC_F_U] <= 1'b0;
					state_q <= S_PSHF;
				end
				S_PSHF, S_PSHP:
				begin
					if (odd_q && !bph_q)
						bph_q <= 1'b1;
					else
					begin
						bph_q <= 1'b0;
						if (use_usp_q)
							usp_q <= usp_q - 16'h0002;
						else
							isp_q <= isp_q - 16'h0002;
						state_q <= (state_q == S_PSHF) ? S_PSHP : S_VEC;
					end
				end
				S_VEC:
				begin
					if (kind_q == `PIC_K_MASK)
						flag_q[14:12] <= alvl_q;
					else if (kind_q == `PIC_K_WDT)
						flag_q[14:12] <= `PIC_IPL_WDT;
					pc_out <= vec_rdata;
					pc_load <= 1'b1;
					state_q <= S_IDLE;
				end
				S_POPP: state_q <= S_POPF;
				S_POPF:
				begin
					pop_pc_q <= stk_rdata;
					state_q <= S_POPD;
				end
				S_POPD:
				begin
					flag_q <= {flag_q[15], stk_rdata[10:8], flag_q[11:8], stk_rdata[7:0]};
					pc_out <= {stk_rdata[15:12], pop_pc_q};
					pc_load <= 1'b1;
					if (use_usp_q)
						usp_q <= usp_q + 16'h0004;
					else
						isp_q <= isp_q + 16'h0004;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always @*
	begin
		rd_d = 16'h0000;
		case (reg_addr)
			`PIC_A_FLAG: rd_d = flag_q;
			`PIC_A_ISP: rd_d = isp_q;
			`PIC_A_USP: rd_d = usp_q;
			`PIC_A_ESEL: rd_d = {12'h000, esel_q};
			`PIC_A_STAT: rd_d = {2'b00, state_q, best_ok, best_lvl, best_src, kind_q};
			default:
			begin
				if (reg_addr[4:3] == 2'b01)
					rd_d = {11'h000, pol_q[reg_addr[2:0]], pend_q[reg_addr[2:0]], lvl_q[reg_addr[2:0]]};
			end
		endcase
	end

	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_re)
			reg_rdata <= rd_d;
		else
			reg_rdata <= 16'h0000;
	end
endmodule // pic_priority_interrupt_control
`default_nettype wire

// *** pic_priority_interrupt_control_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module pic_ctl_props (
	input wire mclk,
	input wire rst_n,
	input wire reg_re,
	input wire [15:0] reg_rdata,
	input wire instr_done,
	input wire string_op_active,
	input wire suspend,
	input wire seq_busy,
	input wire info_rd,
	input wire [19:0] info_addr,
	input wire vec_rd,
	input wire [19:0] vec_rdata,
	input wire stk_we,
	input wire stk_re,
	input wire stk_byte,
	input wire [19:0] stk_addr,
	input wire pc_load,
	input wire [19:0] pc_out,
	input wire [15:0] flags_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_RD_IDLE: assert property (!$past(reg_re) |-> reg_rdata == 16'h0000) else $error("read data not idle");
	AST_INFO_ADDR: assert property (info_rd |-> info_addr == 20'h00000 ##1 !info_rd) else $error("bad info address");
	AST_LATENCY: assert property (info_rd |-> ##[5:7] pc_load) else $error("entry too slow");
	AST_FLAGS_CLR: assert property ($rose(stk_we) |-> !flags_out[6] && !flags_out[2]) else $error("flags kept");
	AST_WORD_PAIR: assert property (($rose(stk_we) && !stk_byte) |=> stk_we && stk_addr == $past(stk_addr) - 20'h2) else $error("word push order");
	AST_BYTE_SPLIT: assert property ((stk_we && stk_byte && !stk_addr[0]) |=> stk_we && stk_byte && stk_addr == $past(stk_addr) - 20'h1) else $error("byte push order");
	AST_PUSH_VEC: assert property (vec_rd |-> $past(stk_we)) else $error("vector before push");
	AST_VEC_PC: assert property (vec_rd |=> pc_load && pc_out == $past(vec_rdata)) else $error("vector not loaded");
	AST_POP_PAIR: assert property ($rose(stk_re) |=> stk_re && stk_addr == $past(stk_addr) + 20'h2) else $error("pop order");
	AST_SUSPEND: assert property (suspend |-> string_op_active && !instr_done ##1 seq_busy) else $error("bad suspend");
	COV_INFO: cover property (info_rd);
	COV_BYTE: cover property (stk_we && stk_byte);
	COV_POP: cover property (stk_re);
	COV_SUSP: cover property (suspend);
endmodule // pic_ctl_props
bind pic_priority_interrupt_control pic_ctl_props u_props (.mclk(mclk), .rst_n(rst_n), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .instr_done(instr_done), .string_op_active(string_op_active), .suspend(suspend),
	.seq_busy(seq_busy),
	.info_rd(info_rd), .info_addr(info_addr), .vec_rd(vec_rd), .vec_rdata(vec_rdata), .stk_we(stk_we),
	.stk_re(stk_re), .stk_byte(stk_byte), .stk_addr(stk_addr), .pc_load(pc_load), .pc_out(pc_out),
	.flags_out(flags_out));
`default_nettype wire

// *** pic_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pic_mem_model (
	input wire mclk,
	input wire vec_rd,
	input wire [19:0] vec_addr,
	output logic [19:0] vec_rdata,
	input wire stk_we,
	input wire stk_re,
	input wire stk_byte,
	input wire [19:0] stk_addr,
	input wire [15:0] stk_wdata,
	output logic [15:0] stk_rdata
);
	logic [7:0] mem [0:255];
	// vector differs per address; off-cycle lines show the inverse, never a stale value
	assign vec_rdata = vec_rd ? (vec_addr ^ 20'h5a5a4) : ~vec_addr;
	initial stk_rdata = 16'h5a5a;
	always @(posedge mclk)
	begin
		if (stk_we)
		begin
			mem[stk_addr[7:0]] <= stk_wdata[7:0];
			if (!stk_byte)
				mem[stk_addr[7:0] + 8'h01] <= stk_wdata[15:8];
		end
		if (stk_re)
			stk_rdata <= {mem[stk_addr[7:0] + 8'h01], mem[stk_addr[7:0]]};
		else
			stk_rdata <= ~stk_rdata;
	end
endmodule // pic_mem_model
`default_nettype wire

// *** tb_priority_interrupt_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_priority_interrupt_control;
	logic mclk = 0, rst_n = 0, reg_we = 0, reg_re = 0, instr_done = 0, string_op_active = 0;
	logic trap_req = 0, wdt_req = 0, reti_req = 0, saw_susp = 0;
	logic dbc_req = 0, step_req = 0, addr_match_req = 0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, stk_wdata, stk_rdata, flags_out;
	logic [3:0] periph_req = 4'h0, ext_pin = 4'h0;
	logic [5:0] trap_num = 6'h00;
	logic [19:0] cur_pc = 20'h12345, info_addr, vec_addr, vec_rdata, stk_addr, pc_out;
	logic seq_busy, suspend, info_rd, vec_rd, stk_we, stk_re, stk_byte, pc_load;
	integer errors = 0, n_tests = 0, i;
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (suspend === 1'b1) saw_susp <= 1'b1;
	pic_priority_interrupt_control dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .ext_pin(ext_pin), .periph_req(periph_req),
		.instr_done(instr_done), .string_op_active(string_op_active), .trap_req(trap_req), .trap_num(trap_num),
		.dbc_req(dbc_req), .wdt_req(wdt_req), .step_req(step_req), .addr_match_req(addr_match_req),
		.reti_req(reti_req),
		.cur_pc(cur_pc), .seq_busy(seq_busy), .suspend(suspend), .info_rd(info_rd), .info_addr(info_addr),
		.vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .stk_we(stk_we), .stk_re(stk_re),
		.stk_byte(stk_byte), .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata),
		.pc_load(pc_load), .pc_out(pc_out), .flags_out(flags_out));
	pic_mem_model mem (.mclk(mclk), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_rdata(vec_rdata), .stk_we(stk_we),
		.stk_re(stk_re), .stk_byte(stk_byte), .stk_addr(stk_addr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));
	task chk(input [19:0] g, input [19:0] e);
	begin
		n_tests = n_tests + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	task wr(input [4:0] a, input [15:0] d);
	begin
		@(posedge mclk) {reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
		@(posedge mclk) reg_we <= 1'b0;
	end
	endtask
	task rd(input [4:0] a, input [15:0] e);
	begin
		@(posedge mclk) {reg_addr, reg_re} <= {a, 1'b1};
		@(posedge mclk) reg_re <= 1'b0;
		#1 chk(reg_rdata, e);
	end
	endtask
	// one instruction completes; with no request eligible the sequencer must stay idle
	task done_idle;
	begin
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		repeat (3) @(posedge mclk) #1 chk(seq_busy, 1'b0);
	end
	endtask
	task wait_pc(input [19:0] e);
	begin
		for (i = 0; i < 20 && pc_load !== 1'b1; i = i + 1) @(posedge mclk) #1;
		chk(pc_load, 1'b1);
		chk(pc_out, e);
	end
	endtask
	task s_reset;
	begin
		rd(5'h00, 16'h0000);
		rd(5'h1f, 16'h0000);
		rd(5'h0c, 16'h0000);
	end
	endtask
	task s_mask_even;
	begin
		wr(5'h01, 16'h0080);
		wr(5'h0c, 16'h0003);
		wr(5'h0d, 16'h0003);
		wr(5'h00, 16'h0040);
		@(posedge mclk) periph_req <= 4'h3;
		@(posedge mclk) periph_req <= 4'h0;
		rd(5'h0c, 16'h000b);
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hffd54 ^ 20'h5a5a4);
		rd(5'h00, 16'h3000);
		rd(5'h0c, 16'h0003);
		rd(5'h0d, 16'h000b);
		chk({mem.mem[8'h7f], mem.mem[8'h7e]}, 16'h1040);
		chk({mem.mem[8'h7d], mem.mem[8'h7c]}, 16'h2345);
		@(posedge mclk) reti_req <= 1'b1;
		@(posedge mclk) reti_req <= 1'b0;
		wait_pc(20'h12345);
		rd(5'h00, 16'h0040);
		wr(5'h0d, 16'h0003);
		rd(5'h0d, 16'h0003);
	end
	endtask
	task s_threshold;
	begin
		@(posedge mclk) periph_req <= 4'h1;
		@(posedge mclk) periph_req <= 4'h0;
		wr(5'h00, 16'h0000);
		done_idle;
		wr(5'h00, 16'h7040);
		done_idle;
		wr(5'h00, 16'h3040);
		done_idle;
		rd(5'h0c, 16'h000b);
		wr(5'h00, 16'h2040);
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hffd54 ^ 20'h5a5a4);
	end
	endtask
	task s_trap_odd;
	begin
		wr(5'h02, 16'h0091);
		wr(5'h00, 16'h0080);
		@(posedge mclk) {trap_req, trap_num, instr_done} <= {1'b1, 6'd40, 1'b1};
		@(posedge mclk) {trap_req, instr_done} <= 2'b00;
		wait_pc(20'hffda0 ^ 20'h5a5a4);
		rd(5'h00, 16'h0080);
		chk({mem.mem[8'h90], mem.mem[8'h8f]}, 16'h1080);
		chk({mem.mem[8'h8e], mem.mem[8'h8d]}, 16'h2345);
	end
	endtask
	task s_wdt_suspend;
	begin
		wr(5'h00, 16'h0040);
		@(posedge mclk) {periph_req, wdt_req} <= {4'h1, 1'b1};
		@(posedge mclk) {periph_req, wdt_req, string_op_active} <= {4'h0, 1'b0, 1'b1};
		@(posedge mclk) string_op_active <= 1'b0;
		wait_pc(20'hfffec ^ 20'h5a5a4);
		chk(saw_susp, 1'b1);
		rd(5'h00, 16'h7000);
		rd(5'h0c, 16'h000b);
	end
	endtask
	// input 0 on both edges, input 1 on rising only
	task s_ext_edges;
	begin
		wr(5'h03, 16'h0001);
		wr(5'h08, 16'h0005);
		wr(5'h09, 16'h0014);
		@(posedge mclk) ext_pin <= 4'h3;
		rd(5'h08, 16'h000d);
		rd(5'h09, 16'h001c);
		wr(5'h08, 16'h0005);
		wr(5'h09, 16'h0014);
		@(posedge mclk) ext_pin <= 4'h0;
		rd(5'h08, 16'h000d);
		rd(5'h09, 16'h0014);
	end
	endtask
	// break, maskable, single-step and address match all waiting at once
	task s_specials;
	begin
		wr(5'h00, 16'h0044);
		@(posedge mclk) {dbc_req, step_req, addr_match_req} <= 3'b111;
		@(posedge mclk) {dbc_req, step_req, addr_match_req} <= 3'b000;
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hfffe8 ^ 20'h5a5a4);
		rd(5'h00, 16'h0000);
		wr(5'h00, 16'h0044);
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hffd74 ^ 20'h5a5a4);
		rd(5'h00, 16'h5000);
		wr(5'h00, 16'h0004);
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hffff0 ^ 20'h5a5a4);
		@(posedge mclk) instr_done <= 1'b1;
		@(posedge mclk) instr_done <= 1'b0;
		wait_pc(20'hffff4 ^ 20'h5a5a4);
		rd(5'h00, 16'h0000);
		done_idle;
	end
	endtask
	task wrap_up;
	begin
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		s_reset;
		s_mask_even;
		s_threshold;
		s_trap_odd;
		s_wdt_suspend;
		s_ext_edges;
		s_specials;
		wrap_up;
	end
	initial
	begin
		#100000;
		errors = errors + 1;
		wrap_up;
	end
endmodule // tb_priority_interrupt_control
`default_nettype wire
